/* File: src/electronic_gearing_follower.sv */
// Electronic gearing follower with APB register file
//------------------------------------------------------------
// Functional notes
// - Motor follows selected master velocity, external master times ratio
// - Program start selects external master, ratio one
// - Enable and disable commands; gearing off by default
// - Disable while moving decelerates at accel limit
// - Gearing velocity change limited to accel setting
// - Soft start backlogs unfollowed external master counts, pays later
// - Unset accel defaults to half maximum at start
// - Enable with master moving limits acceleration
// - Index, absolute and jog moves superimpose gearing
// - Five trigger selections gate move start
// - Commanded equals normal plus gearing position
// - Normal position changes only from moves and normal writes
// - Normal write sets commanded, clears master
// - Master count wraps with sign reversed
// - Master position read scaled by ratio
// - Master position cleared at reset, write, start
// - Master velocity read signed, scaled per second
// - Gearing forced off on error or start
// - Limits during gearing raise motion errors
// - Internal master velocity is not ratio scaled
// - Ratio positive, up to sixteen, fine steps
//------------------------------------------------------------
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "gear_cfg.svh"
module electronic_gearing_follower #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Master encoder, trigger events and limit switches
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic event1,
  input wire logic event2,
  input wire logic limit_pos,
  input wire logic limit_neg,
  // Motion status
  output gear_pkg::motion_out_t motion
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic signed [31:0] TPS = 32'(1000000000 / (TICK_CYCLES * `CLK_PERIOD_NS));

  function automatic logic hit(logic [7:0] a, logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic trig_ok(gear_pkg::trig_t t, logic e1, logic e2);
    case (t)
      gear_pkg::TRIG_NONE: trig_ok = 1'b1;
      gear_pkg::TRIG_E1_ACT: trig_ok = e1;
      gear_pkg::TRIG_E1_INACT: trig_ok = !e1;
      gear_pkg::TRIG_E2_ACT: trig_ok = e2;
      gear_pkg::TRIG_E2_INACT: trig_ok = !e2;
      default: trig_ok = 1'b0;
    endcase
  endfunction

  logic acc;
  logic wr;
  logic wr_ctrl;
  logic prog_start;
  logic tr_on;
  logic tr_off;
  logic wr_normal;
  logic wr_move;
  logic [3:0] pin_raw;
  logic [3:0] pin_s;
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  logic step_up;
  logic step_dn;
  logic signed [15:0] mstep;
  logic signed [15:0] mcnt_reg;
  logic signed [15:0] mvel_reg;
  logic signed [31:0] mpos_reg;
  logic src_int_reg;
  logic [27:0] ratio_reg;
  logic signed [31:0] ivel_reg;
  logic signed [31:0] accel_reg;
  logic accel_set_reg;
  gear_pkg::trig_t trig_reg;
  logic lim_en_reg;
  logic signed [31:0] speed_reg;
  logic gear_on_reg;
  logic gerr_reg;
  logic lerr_reg;
  logic signed [31:0] vel_reg;
  logic signed [47:0] bl_reg;
  logic signed [47:0] gpos_reg;
  logic signed [44:0] mprod;
  logic signed [31:0] mscaled;
  logic signed [31:0] src_vel;
  logic signed [47:0] want;
  logic signed [31:0] dv;
  logic signed [31:0] dvc;
  logic signed [31:0] vel_next;
  logic signed [47:0] bl_next;
  logic gerr_set;
  logic lerr_set;
  logic lim_hit;
  logic gear_fault;
  gear_pkg::mstate_t state_reg;
  gear_pkg::move_t kind_reg;
  logic signed [31:0] arg_reg;
  logic signed [31:0] tgt_reg;
  logic signed [31:0] normal_reg;
  logic signed [31:0] idiff;
  logic signed [31:0] istep;
  logic signed [60:0] mpos_prod;
  logic signed [63:0] mvel_prod;
  logic [31:0] rd_val;
  logic mapped;

  //------------------------------------------------------------
  // Pin synchronisers and motion tick
  //------------------------------------------------------------
  assign pin_raw = {limit_neg, limit_pos, event2, event1};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      logic [2:0] sh_reg;
      logic lvl_reg;
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          sh_reg <= 3'h0;
          lvl_reg <= 1'b0;
        end else begin
          sh_reg <= {sh_reg[1:0], pin_raw[gi]};
          if (sh_reg[1] == sh_reg[2]) lvl_reg <= sh_reg[2];
        end
      end
      assign pin_s[gi] = lvl_reg;
    end
  endgenerate

  assign tick = (tick_cnt_reg == '0);

  always_ff @(posedge core_clk) begin
    if (sys_rst || tick) tick_cnt_reg <= TW'(TICK_CYCLES - 1);
    else tick_cnt_reg <= tick_cnt_reg - 1'b1;
  end

  //------------------------------------------------------------
  // Register writes
  //------------------------------------------------------------
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign wr_ctrl = wr && hit(paddr, `A_CTRL);
  assign prog_start = wr_ctrl && pwdata[`C_START];
  assign tr_on = wr_ctrl && pwdata[`C_ON];
  assign tr_off = wr_ctrl && pwdata[`C_OFF];
  assign wr_normal = wr && hit(paddr, `A_NORMAL);
  assign wr_move = wr && (hit(paddr, `A_MVREL) || hit(paddr, `A_MVABS) || hit(paddr, `A_JOG));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src_int_reg <= 1'b0;
      ratio_reg <= `RATIO_ONE;
      ivel_reg <= '0;
      accel_reg <= `ACCEL_DEF;
      accel_set_reg <= 1'b0;
      trig_reg <= gear_pkg::TRIG_NONE;
      lim_en_reg <= 1'b0;
      speed_reg <= `SPEED_RST;
    end else if (prog_start) begin
      src_int_reg <= 1'b0;
      ratio_reg <= `RATIO_ONE;
      if (!accel_set_reg) accel_reg <= `ACCEL_DEF;
    end else if (wr) begin
      if (wr_ctrl) begin
        if (pwdata[`C_EXT]) src_int_reg <= 1'b0;
        else if (pwdata[`C_INT]) src_int_reg <= 1'b1;
        trig_reg <= gear_pkg::trig_t'(pwdata[`C_TRIG_HI:`C_TRIG_LO]);
        lim_en_reg <= pwdata[`C_LIMEN];
      end
      // Zero is not a legal ratio and is ignored
      if (hit(paddr, `A_RATIO) && pwdata[27:0] != 28'h000_0000) ratio_reg <= pwdata[27:0];
      if (hit(paddr, `A_IVEL)) ivel_reg <= pwdata;
      if (hit(paddr, `A_ACCEL)) begin
        accel_reg <= pwdata;
        accel_set_reg <= 1'b1;
      end
      if (hit(paddr, `A_SPEED)) speed_reg <= pwdata;
    end
  end

  //------------------------------------------------------------
  // Master encoder count, position and velocity
  //------------------------------------------------------------
  quad_decoder u_quad (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .step_up(step_up),
    .step_dn(step_dn)
  );

  assign mstep = step_up ? 16'sh0001 : (step_dn ? -16'sh0001 : 16'sh0000);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mcnt_reg <= '0;
      mvel_reg <= '0;
    end else if (tick) begin
      mvel_reg <= mcnt_reg + mstep;
      mcnt_reg <= '0;
    end else begin
      mcnt_reg <= mcnt_reg + mstep;
    end
  end

  // The most negative code is skipped so the span stays symmetric
  always_ff @(posedge core_clk) begin
    if (sys_rst || prog_start || wr_normal) mpos_reg <= '0;
    else if (step_up) mpos_reg <= (mpos_reg == `POS_MAX) ? -`POS_MAX : mpos_reg + 1;
    else if (step_dn) mpos_reg <= (mpos_reg == -`POS_MAX) ? `POS_MAX : mpos_reg - 1;
  end

  //------------------------------------------------------------
  // Gearing velocity, backlog and position
  //------------------------------------------------------------
  always_comb begin
    mprod = mvel_reg * $signed({1'b0, ratio_reg});
    mscaled = 32'(mprod >>> 8);
    src_vel = src_int_reg ? ivel_reg : mscaled;
    want = '0;
    if (gear_on_reg) begin
      want = 48'(src_vel);
      // Pay the backlog out a fraction per tick to avoid hunting
      if (!src_int_reg) want = want + (bl_reg >>> `BL_SHIFT);
    end
    dv = 32'(want - 48'(vel_reg));
    if (dv > accel_reg) dvc = accel_reg;
    else if (dv < -accel_reg) dvc = -accel_reg;
    else dvc = dv;
    vel_next = vel_reg + dvc;
    bl_next = '0;
    if (gear_on_reg && !src_int_reg) bl_next = bl_reg + 48'(src_vel) - 48'(vel_next);
  end

  assign lim_hit = lim_en_reg && (pin_s[2] || pin_s[3]);
  assign gerr_set = tick && gear_on_reg && (bl_next > `BL_MAX || bl_next < -`BL_MAX);
  assign lerr_set = lim_hit && (gear_on_reg || state_reg != gear_pkg::MS_IDLE);
  assign gear_fault = gerr_set || lerr_set;

  always_ff @(posedge core_clk) begin
    if (sys_rst || prog_start || gear_fault) gear_on_reg <= 1'b0;
    else if (tr_on) gear_on_reg <= 1'b1;
    else if (tr_off) gear_on_reg <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || prog_start) begin
      vel_reg <= '0;
      bl_reg <= '0;
      gpos_reg <= '0;
    end else begin
      if (tick) begin
        vel_reg <= vel_next;
        bl_reg <= bl_next;
      end
      if (wr_normal) gpos_reg <= '0;
      else if (tick) gpos_reg <= gpos_reg + 48'(vel_next);
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gerr_reg <= 1'b0;
      lerr_reg <= 1'b0;
    end else begin
      gerr_reg <= gerr_set || (gerr_reg && !(wr && hit(paddr, `A_STATUS) && pwdata[`S_GERR]));
      lerr_reg <= lerr_set || (lerr_reg && !(wr && hit(paddr, `A_STATUS) && pwdata[`S_LERR]));
    end
  end

  //------------------------------------------------------------
  // Superimposed moves
  //------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst || prog_start) begin
      state_reg <= gear_pkg::MS_IDLE;
      kind_reg <= gear_pkg::MV_REL;
      arg_reg <= '0;
      tgt_reg <= '0;
    end else if (lerr_set || wr_normal) begin
      state_reg <= gear_pkg::MS_IDLE;
    end else if (wr_move) begin
      if (hit(paddr, `A_MVREL)) kind_reg <= gear_pkg::MV_REL;
      else if (hit(paddr, `A_MVABS)) kind_reg <= gear_pkg::MV_ABS;
      else kind_reg <= gear_pkg::MV_JOG;
      arg_reg <= pwdata;
      state_reg <= gear_pkg::MS_ARMED;
    end else begin
      unique case (state_reg)
        gear_pkg::MS_IDLE: ;
        gear_pkg::MS_ARMED: begin
          if (tick && trig_ok(trig_reg, pin_s[0], pin_s[1])) begin
            unique case (kind_reg)
              gear_pkg::MV_REL: begin
                tgt_reg <= normal_reg + arg_reg;
                state_reg <= gear_pkg::MS_INDEX;
              end
              gear_pkg::MV_ABS: begin
                tgt_reg <= arg_reg;
                state_reg <= gear_pkg::MS_INDEX;
              end
              gear_pkg::MV_JOG: begin
                // A zero jog speed ends a running jog
                if (arg_reg == '0) state_reg <= gear_pkg::MS_IDLE;
                else state_reg <= gear_pkg::MS_JOG;
              end
            endcase
          end
        end
        gear_pkg::MS_INDEX: if (normal_reg == tgt_reg) state_reg <= gear_pkg::MS_IDLE;
        gear_pkg::MS_JOG: ;
      endcase
    end
  end

  always_comb begin
    idiff = tgt_reg - normal_reg;
    if (idiff > speed_reg) istep = speed_reg;
    else if (idiff < -speed_reg) istep = -speed_reg;
    else istep = idiff;
  end

  // Gearing motion never reaches this accumulator
  always_ff @(posedge core_clk) begin
    if (sys_rst) normal_reg <= '0;
    else if (wr_normal) normal_reg <= pwdata;
    else if (tick && state_reg == gear_pkg::MS_INDEX) normal_reg <= normal_reg + istep;
    else if (tick && state_reg == gear_pkg::MS_JOG) normal_reg <= normal_reg + arg_reg;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      motion <= '0;
    end else begin
      motion.cmd_pos <= normal_reg + gpos_reg[47:16];
      motion.gear_on <= gear_on_reg;
      motion.busy <= state_reg != gear_pkg::MS_IDLE;
      motion.gear_err <= gerr_reg;
      motion.lim_err <= lerr_reg;
    end
  end

  //------------------------------------------------------------
  // Register reads and APB answer
  //------------------------------------------------------------
  assign mpos_prod = mpos_reg * $signed({1'b0, ratio_reg});
  assign mvel_prod = mscaled * TPS;

  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    case (paddr)
      `A_CTRL: begin
        rd_val[`C_INT] = src_int_reg;
        rd_val[`C_LIMEN] = lim_en_reg;
        rd_val[`C_TRIG_HI:`C_TRIG_LO] = trig_reg;
      end
      `A_RATIO: rd_val = {4'h0, ratio_reg};
      `A_IVEL: rd_val = ivel_reg;
      `A_ACCEL: rd_val = accel_reg;
      `A_NORMAL: rd_val = normal_reg;
      `A_MVREL, `A_MVABS, `A_JOG: rd_val = '0;
      `A_SPEED: rd_val = speed_reg;
      `A_STATUS: begin
        rd_val[`S_ON] = gear_on_reg;
        rd_val[`S_BUSY] = state_reg != gear_pkg::MS_IDLE;
        rd_val[`S_GERR] = gerr_reg;
        rd_val[`S_LERR] = lerr_reg;
        rd_val[`S_SRC] = src_int_reg;
      end
      `A_MPOS: rd_val = 32'(mpos_prod >>> 24);
      `A_MVEL: rd_val = 32'(mvel_prod >>> 16);
      `A_COMMANDED_POSITION: rd_val = motion.cmd_pos;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !mapped;
      end
    end
  end

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_start_dflt;
    prog_start |=> !src_int_reg && ratio_reg == `RATIO_ONE && !gear_on_reg;
  endproperty
  a_start_dflt: assert property (p_start_dflt) else $error("start defaults wrong");

  property p_fault_off;
    gear_fault |=> !gear_on_reg ##1 motion.gear_on == 1'b0;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("gearing not forced off");

  property p_on;
    tr_on && !gear_fault && !prog_start |=> gear_on_reg;
  endproperty
  a_on: assert property (p_on) else $error("enable command ignored");

  property p_rate;
    tick && !prog_start |=> (vel_reg - $past(vel_reg) <= $past(accel_reg))
      && ($past(vel_reg) - vel_reg <= $past(accel_reg));
  endproperty
  a_rate: assert property (p_rate) else $error("velocity step above accel");

  property p_stop;
    tick && !gear_on_reg && vel_reg > 0 && accel_reg > 0 |=> vel_reg < $past(vel_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("no deceleration when off");

  property p_set_normal;
    wr_normal |=> normal_reg == $signed($past(pwdata)) && mpos_reg == 0 && gpos_reg == 0;
  endproperty
  a_set_normal: assert property (p_set_normal) else $error("normal write effects");

  property p_wrap;
    step_up && mpos_reg == `POS_MAX && !prog_start && !wr_normal |=> mpos_reg == -`POS_MAX;
  endproperty
  a_wrap: assert property (p_wrap) else $error("master wrap wrong");

  property p_trig;
    state_reg == gear_pkg::MS_ARMED && !wr_move && !trig_ok(trig_reg, pin_s[0], pin_s[1])
      |=> state_reg inside {gear_pkg::MS_ARMED, gear_pkg::MS_IDLE};
  endproperty
  a_trig: assert property (p_trig) else $error("move started untriggered");

  property p_accel_dflt;
    prog_start && !accel_set_reg |=> accel_reg == `ACCEL_DEF;
  endproperty
  a_accel_dflt: assert property (p_accel_dflt) else $error("accel default wrong");

  property p_cmd;
    ##1 1'b1 |-> motion.cmd_pos == $past(normal_reg) + $past(gpos_reg[47:16]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("commanded position sum");

  property p_apb;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing");

  c_gear_run: cover property (gear_on_reg && tick && vel_reg != 0);
  c_jog: cover property (state_reg == gear_pkg::MS_JOG && gear_on_reg);
  c_backlog: cover property (gear_on_reg && bl_reg != 0 ##1 bl_reg == 0);
endmodule // electronic_gearing_follower

/* File: src/gear_cfg.svh */
// Register map, field positions, reset values and timing of the gearing follower
`ifndef GEAR_CFG_SVH
`define GEAR_CFG_SVH
// Register byte offsets
`define A_CTRL 8'h00
`define A_RATIO 8'h04
`define A_IVEL 8'h08
`define A_ACCEL 8'h0C
`define A_NORMAL 8'h10
`define A_MVREL 8'h14
`define A_MVABS 8'h18
`define A_JOG 8'h1C
`define A_SPEED 8'h20
`define A_STATUS 8'h24
`define A_MPOS 8'h28
`define A_MVEL 8'h2C
`define A_COMMANDED_POSITION 8'h30
// Control register fields
`define C_ON 0
`define C_OFF 1
`define C_EXT 2
`define C_INT 3
`define C_START 4
`define C_LIMEN 5
`define C_TRIG_LO 8
`define C_TRIG_HI 10
// Status register fields
`define S_ON 0
`define S_BUSY 1
`define S_GERR 2
`define S_LERR 3
`define S_SRC 4
// Reset values and limits
`define RATIO_ONE 28'h100_0000
`define ACCEL_MAX 32'h0010_0000
`define ACCEL_DEF (`ACCEL_MAX >> 1)
`define SPEED_RST 32'h0000_0010
`define POS_MAX 32'h7FFF_FFFF
`define BL_MAX 48'sh0000_0100_0000
`define BL_SHIFT 3
// Timing
`define CLK_PERIOD_NS 8
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_S (1000000000 / `TICK_NS)
`endif

/* File: src/gear_pkg.sv */
// Types shared by the gearing follower
package gear_pkg;
  typedef enum logic [2:0] {
    TRIG_NONE = 3'b000,
    TRIG_E1_ACT = 3'b001,
    TRIG_E1_INACT = 3'b010,
    TRIG_E2_ACT = 3'b011,
    TRIG_E2_INACT = 3'b100
  } trig_t;
  typedef enum logic [1:0] {
    MV_REL = 2'b00,
    MV_ABS = 2'b01,
    MV_JOG = 2'b10
  } move_t;
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_ARMED = 2'b01,
    MS_INDEX = 2'b10,
    MS_JOG = 2'b11
  } mstate_t;
  typedef struct packed {
    logic [31:0] cmd_pos;
    logic gear_on;
    logic busy;
    logic gear_err;
    logic lim_err;
  } motion_out_t;
endpackage

/* File: src/quad_decoder.sv */
// Quadrature decoder for the master encoder port
`timescale 1ns/1ns
module quad_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Encoder phases
  input wire logic enc_a,
  input wire logic enc_b,
  // Count pulses
  output logic step_up,
  output logic step_dn
);
  logic [2:0] a_sh_reg;
  logic [2:0] b_sh_reg;
  logic a_reg;
  logic b_reg;
  logic a_prev_reg;
  logic b_prev_reg;
  logic one_edge;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      a_sh_reg <= 3'h0;
      b_sh_reg <= 3'h0;
    end else begin
      a_sh_reg <= {a_sh_reg[1:0], enc_a};
      b_sh_reg <= {b_sh_reg[1:0], enc_b};
    end
  end

  // Level accepted only once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      if (a_sh_reg[1] == a_sh_reg[2]) a_reg <= a_sh_reg[2];
      if (b_sh_reg[1] == b_sh_reg[2]) b_reg <= b_sh_reg[2];
      a_prev_reg <= a_reg;
      b_prev_reg <= b_reg;
    end
  end

  // A double change is a lost state and is dropped
  assign one_edge = (a_reg ^ a_prev_reg) ^ (b_reg ^ b_prev_reg);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end else begin
      step_up <= one_edge && (a_reg ^ b_prev_reg);
      step_dn <= one_edge && !(a_reg ^ b_prev_reg);
    end
  end
endmodule // quad_decoder

/* File: verification/quad_master_model.sv */
// Quadrature master encoder model for the master encoder port
`timescale 1ns/1ns
module quad_master_model (
  // Clock
  input wire logic core_clk,
  // Encoder phases
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph = 2'b00;
  // Rest at zero velocity until told to move
  initial {enc_a, enc_b} = 2'b00;
  // Gray order, each state held 4 cycles so the synchroniser sees it
  task automatic steps(input int n, input logic up);
    repeat (n) begin
      ph = up ? ph + 2'd1 : ph - 2'd1;
      enc_a <= ph[0] ^ ph[1];
      enc_b <= ph[1];
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule // quad_master_model

/* File: verification/tb_electronic_gearing_follower.sv */
// Self-checking testbench of the electronic gearing follower
`timescale 1ns/1ns
`include "gear_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_electronic_gearing_follower;
  localparam int TK = 16;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, c1, base;
  logic pready, pslverr, rerr, enc_a, enc_b;
  logic event1 = 1'b0;
  logic event2 = 1'b0;
  logic limit_pos = 1'b0;
  logic limit_neg = 1'b0;
  gear_pkg::motion_out_t motion;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  electronic_gearing_follower #(.TICK_CYCLES(TK)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a),
    .enc_b(enc_b), .event1(event1), .event2(event2), .limit_pos(limit_pos),
    .limit_neg(limit_neg), .motion(motion));
  quad_master_model enc_u (.core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b));
  //------------------------------------------------------------
  // Bus access, waits and closing report
  //------------------------------------------------------------
  task automatic end_sim;
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hung run still reaches the report
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  // Releases after the completing edge, then idles one cycle before the next setup
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask
  task automatic wt(input int t);
    repeat (t * TK) @(posedge core_clk);
  endtask
  //------------------------------------------------------------
  // Test sequence
  //------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rchk(`A_RATIO, 32'h0100_0000, "ratio");
    rchk(`A_ACCEL, 32'h0008_0000, "accel");
    rchk(`A_STATUS, 32'h0000_0000, "status");
    rchk(`A_MPOS, 32'h0000_0000, "mpos");
    xfer(1'b0, 8'h40, 32'h0000_0000);
    `CHK("slverr", 1'b1, rerr)
    // Four counts per tick of 16 cycles at 8 ns, ratio one
    fork
      enc_u.steps(16, 1'b1);
      begin
        repeat (36) @(posedge core_clk);
        rchk(`A_MVEL, 32'h01DC_D650, "mvel");
      end
    join
    fork
      enc_u.steps(11, 1'b0);
      begin
        repeat (36) @(posedge core_clk);
        rchk(`A_MVEL, 32'hFE23_29B0, "mvel");
      end
    join
    repeat (8) @(posedge core_clk);
    rchk(`A_MPOS, 32'h0000_0005, "mpos");
    xfer(1'b1, `A_RATIO, 32'h0200_0000);
    xfer(1'b1, `A_RATIO, 32'h0000_0000);
    rchk(`A_RATIO, 32'h0200_0000, "ratio");
    rchk(`A_MPOS, 32'h0000_000A, "mpos");
    xfer(1'b1, `A_NORMAL, 32'h0000_0064);
    rchk(`A_COMMANDED_POSITION, 32'h0000_0064, "commanded_position");
    rchk(`A_MPOS, 32'h0000_0000, "mpos");
    `CHK("cmd_pos", 32'h0000_0064, motion.cmd_pos)
    // Ratio of 2 is already set, internal master runs 32 counts per tick
    xfer(1'b1, `A_IVEL, 32'h0020_0000);
    xfer(1'b1, `A_CTRL, 32'h0000_0009);
    c1 = motion.cmd_pos;
    wt(2);
    `CHK("ramp", 1'b1, motion.cmd_pos - c1 inside {32'h0000_0008, 32'h0000_0018})
    `CHK("gear_on", 1'b1, motion.gear_on)
    rchk(`A_STATUS, 32'h0000_0011, "status");
    wt(64);
    c1 = motion.cmd_pos;
    wt(10);
    `CHK("steady", 32'h0000_0140, motion.cmd_pos - c1)
    xfer(1'b1, `A_CTRL, 32'h0000_0002);
    c1 = motion.cmd_pos;
    wt(2);
    `CHK("rate_setting_a", 1'b1, motion.cmd_pos - c1 inside {32'h0000_0028, 32'h0000_0038})
    wt(20);
    c1 = motion.cmd_pos;
    wt(10);
    `CHK("stop", c1, motion.cmd_pos)
    rchk(`A_NORMAL, 32'h0000_0064, "normal");
    xfer(1'b1, `A_CTRL, 32'h0000_0010);
    rchk(`A_STATUS, 32'h0000_0000, "status");
    rchk(`A_RATIO, 32'h0100_0000, "ratio");
    rchk(`A_ACCEL, 32'h0008_0000, "accel");
    base = motion.cmd_pos;
    // Each of the four event trigger modes first withheld, then met by flipping both events
    for (int m = 1; m <= 4; m++) begin
      event1 <= (m == 2);
      event2 <= (m == 4);
      xfer(1'b1, `A_CTRL, m << 8);
      xfer(1'b1, `A_MVREL, 32'h0000_0004);
      wt(3);
      `CHK("held", base, motion.cmd_pos)
      `CHK("busy", 1'b1, motion.busy)
      event1 <= (m != 2);
      event2 <= (m != 4);
      wt(4);
      base = base + 32'h0000_0004;
      `CHK("moved", base, motion.cmd_pos)
    end
    // Only index, absolute and jog moves are issued, never homing or registration
    xfer(1'b1, `A_CTRL, 32'h0000_0000);
    xfer(1'b1, `A_MVABS, 32'h0000_0064);
    wt(4);
    `CHK("absolute", 32'h0000_0064, motion.cmd_pos)
    xfer(1'b1, `A_JOG, 32'h0000_0002);
    c1 = motion.cmd_pos;
    wt(4);
    `CHK("jog", 1'b1, motion.cmd_pos - c1 inside {32'h0000_0004, 32'h0000_0006})
    xfer(1'b1, `A_JOG, 32'h0000_0000);
    wt(1);
    c1 = motion.cmd_pos;
    wt(3);
    `CHK("jog_stop", c1, motion.cmd_pos)
    rchk(`A_STATUS, 32'h0000_0000, "status");
    xfer(1'b1, `A_CTRL, 32'h0000_0029);
    limit_pos <= 1'b1;
    wt(4);
    `CHK("lim_err", 1'b1, motion.lim_err)
    rchk(`A_STATUS, 32'h0000_0018, "status");
    limit_pos <= 1'b0;
    wt(1);
    xfer(1'b1, `A_STATUS, 32'h0000_0008);
    rchk(`A_STATUS, 32'h0000_0010, "status");
    end_sim();
  end
endmodule // tb_electronic_gearing_follower
